// [common/rcps_defines.svh]
// reset and clock-pin sequencer constants
// assumes inclusion by bare name from any design file
`ifndef RCPS_DEFINES_SVH
`define RCPS_DEFINES_SVH
`define RCPS_RESET_OUT_N_HOLD_CYCLES 512
`define RCPS_CNT_W            10
`define RCPS_CLKSEL_EXTOSC    2'h0
`define RCPS_CLKSEL_ONCHIP    2'h1
`define RCPS_CLKSEL_CRYSTAL   2'h2
`endif

// [common/rcps_pkg.sv]
// types shared by the reset and clock-pin sequencer
// assumes the defines header is on the include path
`include "rcps_defines.svh"
package rcps_pkg;
	typedef enum logic [1:0] {
		RCPS_SRC_EXTOSC  = `RCPS_CLKSEL_EXTOSC,
		RCPS_SRC_ONCHIP  = `RCPS_CLKSEL_ONCHIP,
		RCPS_SRC_CRYSTAL = `RCPS_CLKSEL_CRYSTAL
	} rcps_src_e;
	typedef struct packed {
		logic      pllOn;
		rcps_src_e source;
		logic      flashProg;
	} rcps_cfg_s;
	typedef struct packed {
		logic [1:0] clockBootSelect;
		logic       crystalPin;
		logic       resetConfigPinN;
		logic       testPin;
	} rcps_straps_s;
endpackage : rcps_pkg

// [hdl/rcps_sync2.sv]
// two-flop level synchroniser
// assumes the input is asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module rcps_sync2 #(
	parameter int W     = 1,
	parameter bit RSTVAL = 1'b0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] meta_ff;
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= {W{RSTVAL}};
			dout    <= {W{RSTVAL}};
		end else begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end
endmodule : rcps_sync2
`default_nettype wire

// [hdl/rcps_sequencer.sv]
// reset and clock-pin sequencer: reset fan-out, reset-out stretch, boot straps
// assumes ref_clk is the cpu clock; pins arrive asynchronously
// Overview of operation
// - reset input resets cpu and peripherals immediately
// - reset output low until lock plus 512
// - upper select one samples crystal pin
// - clock output follows system clock
// - external clock used except on-chip oscillator
// - upper select bit chooses pll off/normal
// - lower bit crystal, else pin picks oscillator only when upper select bit set, otherwise external
// - config pin asserted, test low: flash programming
`timescale 1ns/10ps
`default_nettype none
`include "rcps_defines.svh"
module rcps_sequencer #(
	parameter int HOLD_CYCLES = `RCPS_RESET_OUT_N_HOLD_CYCLES
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic                 reset_in_n,
	input  wire logic                 pllLocked,
	input  wire logic                 ext_clock_in,
	input  wire rcps_pkg::rcps_straps_s straps,
	output var  logic                 coreReset,
	output var  logic                 reset_out_n,
	output var  logic                 crystalPinOut,
	output var  logic                 crystalPinOe_n,
	output var  logic                 refClockSel,
	output var  logic                 system_clock_out,
	output var  rcps_pkg::rcps_cfg_s  bootCfg
);
	import rcps_pkg::*;

	typedef enum {ST_HELD, ST_COUNT, ST_RUN} rcps_state_e;

	logic              rstInSync;
	logic              lockSync;
	rcps_straps_s      strapSync;
	rcps_state_e       state_ff;
	rcps_state_e       nxt_state;
	logic [`RCPS_CNT_W-1:0] cnt_ff;
	logic [`RCPS_CNT_W-1:0] nxt_cnt;
	rcps_cfg_s         cfg_ff;
	rcps_cfg_s         nxt_cfg;
	logic              rstoLow_ff;
	logic              relEdge;
	logic              countDone;
	logic              sampleXtal;
	rcps_src_e         decodedSrc;

	localparam logic [`RCPS_CNT_W-1:0] LAST = `RCPS_CNT_W'(HOLD_CYCLES - 1);

	rcps_sync2 #(.W(1), .RSTVAL(1'b0)) uRstSync (
		.clk (ref_clk),
		.rst (rst),
		.din (reset_in_n),
		.dout(rstInSync)
	);
	rcps_sync2 #(.W(1), .RSTVAL(1'b0)) uLockSync (
		.clk (ref_clk),
		.rst (rst),
		.din (pllLocked),
		.dout(lockSync)
	);
	rcps_sync2 #(.W($bits(rcps_straps_s)), .RSTVAL(1'b0)) uStrapSync (
		.clk (ref_clk),
		.rst (rst),
		.din (straps),
		.dout(strapSync)
	);

	// immediate reset path
	// combinational on purpose: reset must not wait for a clock edge
	assign coreReset = ~reset_in_n | rst;

	assign sampleXtal     = strapSync.clockBootSelect[1];
	assign crystalPinOe_n = sampleXtal;
	assign crystalPinOut  = 1'b0;

	assign decodedSrc = strapSync.clockBootSelect[0] ? RCPS_SRC_CRYSTAL :
	                    (strapSync.crystalPin & sampleXtal) ? RCPS_SRC_ONCHIP :
	                    RCPS_SRC_EXTOSC;

	assign refClockSel = (cfg_ff.source != RCPS_SRC_ONCHIP);

	// clock output mirror
	// gated-free mirror; pad buffer inserted in physical design
	assign system_clock_out = ref_clk;

	assign relEdge   = (state_ff == ST_HELD) & rstInSync;
	assign countDone = (cnt_ff == LAST);
	assign reset_out_n = ~rstoLow_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_cfg   = cfg_ff;
		case (state_ff)
			ST_HELD: begin
				nxt_cnt = '0;
				if (relEdge) begin
					nxt_cfg.pllOn     = strapSync.clockBootSelect[1];
					nxt_cfg.source    = decodedSrc;
					nxt_cfg.flashProg = ~strapSync.resetConfigPinN & ~strapSync.testPin;
					nxt_state         = ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (lockSync) begin
					nxt_cnt = cnt_ff + 1'b1;
					if (countDone) begin
						nxt_state = ST_RUN;
					end
				end
			end
			ST_RUN: begin
				nxt_cnt = cnt_ff;
			end
			default: begin
				nxt_state = ST_HELD;
			end
		endcase
		if (!rstInSync) begin
			nxt_state = ST_HELD;
		end
	end

	always_ff @(posedge ref_clk or posedge coreReset) begin
		if (coreReset) begin
			state_ff   <= ST_HELD;
			cnt_ff     <= '0;
			cfg_ff     <= '0;
			rstoLow_ff <= 1'b1;
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			cfg_ff     <= nxt_cfg;
			rstoLow_ff <= (nxt_state != ST_RUN);
		end
	end

	assign bootCfg = cfg_ff;

	sequence s_countDoneLocked;
		(state_ff == ST_COUNT) && lockSync && countDone && rstInSync;
	endsequence

	property p_reset_out_n_release;
		@(posedge ref_clk) disable iff (coreReset)
		s_countDoneLocked |=> reset_out_n;
	endproperty
	a_reset_out_n_release: assert property (p_reset_out_n_release)
		else $error("reset out not released after count");

	property p_reset_out_n_low_while_counting;
		@(posedge ref_clk) disable iff (coreReset)
		(state_ff != ST_RUN) |-> !reset_out_n;
	endproperty
	a_reset_out_n_low_while_counting: assert property (p_reset_out_n_low_while_counting)
		else $error("reset out released early");

	property p_no_lock_no_count;
		@(posedge ref_clk) disable iff (coreReset)
		(state_ff == ST_COUNT && !lockSync && rstInSync) |=> $stable(cnt_ff);
	endproperty
	a_no_lock_no_count: assert property (p_no_lock_no_count)
		else $error("count advanced without lock");

	// enable follows pin
	// checked against the raw pin two edges back, not the synchronised copy
	property p_crystal_pin_oe;
		@(posedge ref_clk) disable iff (coreReset)
		(!$past(rst) && !$past(rst, 2)) |->
			(crystalPinOe_n == $past(straps.clockBootSelect[1], 2));
	endproperty
	a_crystal_pin_oe: assert property (p_crystal_pin_oe)
		else $error("crystal pin driven while sampled");

	property p_refsel;
		@(posedge ref_clk) disable iff (coreReset)
		relEdge |=> (refClockSel == ($past(strapSync.clockBootSelect[0]) |
			~$past(strapSync.crystalPin) | ~$past(strapSync.clockBootSelect[1])));
	endproperty
	a_refsel: assert property (p_refsel)
		else $error("reference clock select wrong after release");

	property p_pll_latch;
		@(posedge ref_clk) disable iff (coreReset)
		relEdge |=> (bootCfg.pllOn == $past(strapSync.clockBootSelect[1]));
	endproperty
	a_pll_latch: assert property (p_pll_latch)
		else $error("pll mode not latched at release");

	property p_src_crystal;
		@(posedge ref_clk) disable iff (coreReset)
		(relEdge && strapSync.clockBootSelect[0]) |=> (bootCfg.source == RCPS_SRC_CRYSTAL);
	endproperty
	a_src_crystal: assert property (p_src_crystal)
		else $error("crystal source not selected");

	property p_flash_prog;
		@(posedge ref_clk) disable iff (coreReset)
		relEdge |=> (bootCfg.flashProg ==
			(~$past(strapSync.resetConfigPinN) & ~$past(strapSync.testPin)));
	endproperty
	a_flash_prog: assert property (p_flash_prog)
		else $error("flash programming mode wrong");

	property p_cfg_hold;
		@(posedge ref_clk) disable iff (coreReset)
		(state_ff == ST_RUN) |=> $stable(bootCfg);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("boot config changed after release");
endmodule : rcps_sequencer
`default_nettype wire

// [tb/rcps_pll_model.sv]
// pll lock model standing beside the sequencer
// assumes lockEn comes from the bench, clocked by ref_clk
`timescale 1ns/10ps
`default_nettype none
module rcps_pll_model #(
	parameter int LOCK_DLY = 5
) (
	input  wire logic ref_clk,
	input  wire logic lockEn,
	output var  logic pllLocked
);
	int cnt = 0;
	// lock drops at once but needs time to settle again
	always @(posedge ref_clk or negedge lockEn) begin
		if (!lockEn) begin
			cnt <= 0;
			pllLocked <= 1'b0;
		end else begin
			if (cnt < LOCK_DLY) cnt <= cnt + 1;
			pllLocked <= (cnt >= LOCK_DLY - 1);
		end
	end
endmodule : rcps_pll_model
`default_nettype wire

// [tb/rcps_sequencer_tb.sv]
// self-checking bench for the reset and clock-pin sequencer
// assumes the package and the pll lock model are compiled first
`timescale 1ns/10ps
`default_nettype none
module rcps_sequencer_tb;
	import rcps_pkg::*;
	localparam int HOLD = 8;
	localparam int LDLY = 5;
	logic         ref_clk = 1'b0;
	logic         rst = 1'b1;
	logic         resetInN = 1'b0;
	logic         lockEn = 1'b1;
	logic         pllLocked;
	rcps_straps_s straps = '0;
	logic         coreReset, resetOutN, xtalOeN, xtalOut, refSel, sysClkOut;
	rcps_cfg_s    bootCfg;
	logic [4:0]   expQ[$];
	int           fails = 0;
	int           testsRun = 0;

	always #5 ref_clk = ~ref_clk;

	rcps_pll_model #(.LOCK_DLY(LDLY)) i_pll (.ref_clk(ref_clk), .lockEn(lockEn),
		.pllLocked(pllLocked));
	rcps_sequencer #(.HOLD_CYCLES(HOLD)) i_dut (.ref_clk(ref_clk), .rst(rst),
		.reset_in_n(resetInN), .pllLocked(pllLocked), .ext_clock_in(1'b0),
		.straps(straps), .coreReset(coreReset), .reset_out_n(resetOutN),
		.crystalPinOut(xtalOut), .crystalPinOe_n(xtalOeN), .refClockSel(refSel),
		.system_clock_out(sysClkOut), .bootCfg(bootCfg));

	task automatic chk(string nm, logic [4:0] exp, logic [4:0] got);
		testsRun++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic printVerdict();
		$display("comparisons %0d mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : printVerdict

	// oldest note is due when reset output releases
	always @(posedge resetOutN) begin
		#1;
		if (expQ.size() == 0) chk("spurious release", 5'h00, 5'h1f);
		else chk("bootCfg refClockSel", expQ.pop_front(), {bootCfg, refSel});
	end

	// twelve passes of at most 66 falling edges each, plus reset and margin
	initial begin
		#((12 * (6 + 60) + 100) * 10);
		fails++;
		printVerdict();
	end

	initial begin
		int n, mode, minN;
		logic [4:0] s;
		rcps_src_e src;
		void'($urandom(33));
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		for (int i = 0; i < 12; i++) begin
			mode = i % 3;
			s = 5'($urandom());
			// first eight passes walk every select and crystal-pin combination
			if (i < 8) begin
				s = {3'(i), 2'(i >> 1)};
			end
			@(negedge ref_clk);
			resetInN = 1'b0;
			straps = s;
			lockEn = (mode != 1);
			#1 chk("coreReset reset_out_n", 5'h02, {3'h0, coreReset, resetOutN});
			repeat (3) @(negedge ref_clk);
			@(posedge ref_clk);
			#1 chk("system_clock_out high", 5'h01, {4'h0, sysClkOut});
			@(negedge ref_clk);
			#1 chk("system_clock_out low", 5'h00, {4'h0, sysClkOut});
			@(negedge ref_clk);
			src = s[3] ? RCPS_SRC_CRYSTAL : ((s[4] & s[2]) ? RCPS_SRC_ONCHIP : RCPS_SRC_EXTOSC);
			expQ.push_back({s[4], src, ~s[1] & ~s[0], src != RCPS_SRC_ONCHIP});
			resetInN = 1'b1;
			lockEn = 1'b1;
			minN = (mode != 0) ? HOLD + LDLY : HOLD + 1;
			for (n = 1; n < 60 && resetOutN !== 1'b1; n++) begin
				@(negedge ref_clk);
				if (n == 3) begin
					chk("crystalPinOe_n", {4'h0, s[4]}, {4'h0, xtalOeN});
					chk("crystalPinOut", 5'h00, {4'h0, xtalOut});
					chk("coreReset reset_out_n counting", 5'h00, {3'h0, coreReset, resetOutN});
					straps = ~s;
				end
				lockEn = !(mode == 2 && n == 4);
			end
			chk("release delay", 5'h01, {4'h0, (n - 1 >= minN && n - 1 <= minN + 14)});
			$display("test %0d done, mode %0d", i, mode);
		end
		printVerdict();
	end
endmodule : rcps_sequencer_tb
`default_nettype wire
